//--- sim/debug_host_model.sv
// Debug host model: turns serial write commands into debug port strobes.
// Assumes the bench calls write_byte; a gap stands for a slow serial command.
`timescale 1ns/100ps
`default_nettype none
module debug_host_model (
    // Clock
    input  wire logic                    ref_clk,
    // Debug port toward the device
    output var sysctl_pkg::reg_access_t  dbg_access
);
    import sysctl_pkg::*;
    initial dbg_access = '0;
    task automatic write_byte(input logic [2:0] a, input logic [7:0] d, input int gap);
        repeat (gap) @(posedge ref_clk);
        @(posedge ref_clk);
        dbg_access <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(posedge ref_clk);
        // Released lines carry no stale value
        dbg_access <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask
endmodule
`default_nettype wire

//--- sim/sysctl_asserts.sv
// Port checker for the system options and wakeup control block.
// Assumes it is bound onto system_options_rti_control, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module sysctl_asserts (
    input wire logic                     ref_clk,
    input wire logic                     arst_n,
    input wire sysctl_pkg::reg_access_t  cpu_access,
    input wire logic [7:0]               cpu_rdata,
    input wire logic                     cpu_rvalid,
    input wire sysctl_pkg::reg_access_t  dbg_access,
    input wire logic                     stop_exec,
    input wire sysctl_pkg::reset_cause_t reset_req,
    input wire logic                     stop_enter,
    input wire logic                     wakeup_irq,
    input wire logic                     watchdog_enable,
    input wire logic                     watchdog_long_timeout,
    input wire logic                     stop_permit,
    input wire logic                     debug_pin_enable,
    input wire logic                     wakeup_flag
);
    import sysctl_pkg::*;
    logic force_wr;
    assign force_wr = dbg_access.wr && dbg_access.addr == ADDR_DEBUG_FORCE && dbg_access.data[0];
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    sequence rd_s(a);
        cpu_access.rd && cpu_access.addr == a;
    endsequence
    // Options output lags its register, so a write just before makes it stale
    sequence stop_req_s;
        stop_exec && !$past(cpu_access.wr);
    endsequence
    force_pulse_a: assert property (force_wr |=> reset_req.debug_forced)
        else $error("debug force write gave no reset request");
    force_cause_a: assert property (reset_req.debug_forced |-> $past(force_wr))
        else $error("forced reset without debug write");
    force_read_a: assert property (rd_s(ADDR_DEBUG_FORCE) |=> cpu_rvalid && cpu_rdata == 8'h00)
        else $error("force register read not zero");
    opts_gap_a: assert property (rd_s(ADDR_SYS_OPTIONS) |=> cpu_rdata[3:2] == 2'h0)
        else $error("options gap bits not zero");
    wake_gap_a: assert property (rd_s(ADDR_WAKEUP_CTRL) |=> !cpu_rdata[6] && !cpu_rdata[3])
        else $error("wakeup unused bits not zero");
    stop_gate_a: assert property (stop_req_s |=> stop_enter == $past(stop_permit)
        && reset_req.illegal_opcode == !$past(stop_permit))
        else $error("stop outcome wrong");
    ack_clear_a: assert property (cpu_access.wr && cpu_access.addr == ADDR_WAKEUP_CTRL
        && cpu_access.data[6] |-> ##2 !wakeup_flag)
        else $error("acknowledge did not clear flag");
    irq_gate_a: assert property (wakeup_irq |-> wakeup_flag)
        else $error("interrupt without flag");
    reset_vals_a: assert property ($rose(arst_n) |-> watchdog_enable && watchdog_long_timeout
        && debug_pin_enable && !stop_permit)
        else $error("option outputs wrong after reset");
    wdog_off_a: assert property ((!watchdog_enable)[*3] |-> !reset_req.watchdog)
        else $error("disabled watchdog requested reset");
endmodule
bind system_options_rti_control sysctl_asserts chk_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .cpu_access(cpu_access), .cpu_rdata(cpu_rdata),
    .cpu_rvalid(cpu_rvalid), .dbg_access(dbg_access), .stop_exec(stop_exec),
    .reset_req(reset_req), .stop_enter(stop_enter), .wakeup_irq(wakeup_irq),
    .watchdog_enable(watchdog_enable), .watchdog_long_timeout(watchdog_long_timeout),
    .stop_permit(stop_permit), .debug_pin_enable(debug_pin_enable), .wakeup_flag(wakeup_flag)
);
`default_nettype wire

//--- sim/tb_top.sv
// Bench for the system control block: registers, watchdog, stop, wakeup timer
// and debug force reset. Assumes shortened timer counts set below.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import sysctl_pkg::*;
    localparam int SHORT = 16;
    localparam int LONG  = 64;
    localparam int TICK  = 4;
    localparam int LIMIT = 12000;
    // External tick comes every second cycle
    localparam logic [7:0] WK_CFG [4] = '{8'h10, 8'h13, 8'h31, 8'h32};
    localparam int         WK_CYC [4] = '{8 * TICK, 64 * TICK, 256 * 2, 1024 * 2};
    logic         ref_clk, arst_n, cpu_rvalid, stop_exec, ext_clk_tick, tick_run;
    logic         stop_enter, wakeup_irq, wdog_en, wdog_long, stop_permit, dbg_pin_en;
    logic         wakeup_flag;
    logic [7:0]   cpu_rdata;
    reg_access_t  cpu_access, dbg_access;
    reset_cause_t reset_req, df_cause;
    int           mismatches, num_checks, cycles, wd_cnt, il_cnt, df_cnt, st_cnt, n;

    system_options_rti_control #(
        .WDOG_SHORT_CYCLES(SHORT), .WDOG_LONG_CYCLES(LONG), .RTI_TICK_CYCLES(TICK)
    ) dut_u (
        .ref_clk(ref_clk), .arst_n(arst_n), .cpu_access(cpu_access), .cpu_rdata(cpu_rdata),
        .cpu_rvalid(cpu_rvalid), .dbg_access(dbg_access), .stop_exec(stop_exec),
        .ext_clk_tick(ext_clk_tick), .reset_req(reset_req), .stop_enter(stop_enter),
        .wakeup_irq(wakeup_irq), .watchdog_enable(wdog_en), .watchdog_long_timeout(wdog_long),
        .stop_permit(stop_permit), .debug_pin_enable(dbg_pin_en), .wakeup_flag(wakeup_flag)
    );
    debug_host_model host_u (.ref_clk(ref_clk), .dbg_access(dbg_access));

    initial ref_clk = 1'b0;
    always #25 ref_clk = ~ref_clk;

    task automatic tally_and_finish();
        if (mismatches == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        wd_cnt <= wd_cnt + int'(reset_req.watchdog);
        il_cnt <= il_cnt + int'(reset_req.illegal_opcode);
        df_cnt <= df_cnt + int'(reset_req.debug_forced);
        st_cnt <= st_cnt + int'(stop_enter);
        if (reset_req.debug_forced) begin
            df_cause <= reset_req;
        end
        ext_clk_tick <= tick_run & ~ext_clk_tick;
        if (cycles == LIMIT) begin
            mismatches++;
            $display("[ERR] %0t run timed out", $time);
            tally_and_finish();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cpu_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        cpu_access <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(posedge ref_clk);
        cpu_access <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask

    task automatic cpu_rd(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge ref_clk);
        cpu_access <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(posedge ref_clk);
        cpu_access <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: 8'hff};
        #1;
        check({7'h00, cpu_rvalid}, 8'h01, "read valid");
        check(cpu_rdata, exp, what);
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask

    // Cycles until a watchdog request (wd) or the wakeup flag; none expected if lo == hi
    task automatic wait_event(input bit wd, input int lo, input int hi, input string what);
        int w0;
        int k;
        w0 = wd_cnt;
        k = 0;
        // The flag output lags its ack by two cycles, so an old flag would end the wait
        if (!wd) begin
            settle(2);
            k = 2;
        end
        while (!(wd ? wd_cnt != w0 : wakeup_flag === 1'b1) && k < hi) begin
            settle(1);
            k++;
        end
        num_checks++;
        if (k < lo || k > hi) begin
            mismatches++;
            $display("[ERR] %0t %s after %0d cycles", $time, what, k);
        end
    endtask

    task automatic do_stop(input logic permit);
        int s0;
        int i0;
        s0 = st_cnt;
        i0 = il_cnt;
        @(posedge ref_clk);
        stop_exec <= 1'b1;
        @(posedge ref_clk);
        stop_exec <= 1'b0;
        settle(3);
        check(8'(st_cnt - s0), {7'h00, permit}, "stop entry");
        check(8'(il_cnt - i0), {7'h00, !permit}, "illegal stop");
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        arst_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        settle(1);
    endtask

    initial begin
        arst_n = 1'b0;
        cpu_access = '0;
        stop_exec = 1'b0;
        ext_clk_tick = 1'b0;
        tick_run = 1'b0;
        {mismatches, num_checks, cycles, wd_cnt, il_cnt, df_cnt, st_cnt} = '0;
        do_reset();
        check({4'h0, wdog_en, wdog_long, stop_permit, dbg_pin_en}, 8'h0d, "opt outs");
        cpu_rd(ADDR_SYS_OPTIONS, 8'hc2, "options reset");
        cpu_rd(ADDR_DEBUG_FORCE, 8'h00, "force read");
        cpu_wr(ADDR_PART_ID_LOW, 8'h00);
        cpu_rd(ADDR_PART_ID_HIGH, {4'h0, PART_ID_DEFAULT[11:8]}, "id high");
        cpu_rd(ADDR_PART_ID_LOW, PART_ID_DEFAULT[7:0], "id low");
        cpu_rd(3'h7, 8'h00, "unmapped read");
        n = df_cnt;
        cpu_wr(ADDR_DEBUG_FORCE, 8'hff);
        settle(3);
        check(8'(df_cnt - n), 8'h00, "cpu force write");
        cpu_wr(ADDR_RESET_STATUS, 8'h5a);
        wait_event(1, LONG, LONG + 4, "long timeout");
        n = wd_cnt;
        repeat (4) begin
            settle(LONG - 20);
            cpu_wr(ADDR_RESET_STATUS, 8'h00);
        end
        check(8'(wd_cnt - n), 8'h00, "watchdog kicked");
        cpu_wr(ADDR_SYS_OPTIONS, 8'h2c);
        cpu_rd(ADDR_SYS_OPTIONS, 8'h20, "first write");
        cpu_wr(ADDR_SYS_OPTIONS, 8'hc2);
        cpu_rd(ADDR_SYS_OPTIONS, 8'h20, "second write");
        check({4'h0, wdog_en, wdog_long, stop_permit, dbg_pin_en}, 8'h02, "opt outs");
        wait_event(1, 3 * LONG, 3 * LONG, "watchdog off");
        do_stop(1'b1);
        tick_run = 1'b1;
        cpu_wr(ADDR_WAKEUP_CTRL, 8'h07);
        for (int i = 0; i < 4; i++) begin
            cpu_wr(ADDR_WAKEUP_CTRL, WK_CFG[i] | 8'h40);
            wait_event(0, WK_CYC[i] - 4, WK_CYC[i] + 6, "wakeup period");
            cpu_rd(ADDR_WAKEUP_CTRL, WK_CFG[i] | 8'h80, "wakeup status");
            check({7'h00, wakeup_irq}, 8'h01, "wakeup irq");
        end
        cpu_wr(ADDR_WAKEUP_CTRL, 8'h02);
        settle(2);
        check({6'h00, wakeup_flag, wakeup_irq}, 8'h02, "ack zero");
        cpu_wr(ADDR_WAKEUP_CTRL, 8'h42);
        settle(2);
        check({7'h00, wakeup_flag}, 8'h00, "ack one");
        cpu_wr(ADDR_WAKEUP_CTRL, 8'h70);
        wait_event(0, 600, 600, "external off");
        n = df_cnt;
        host_u.write_byte(ADDR_DEBUG_FORCE, 8'hfe, 5);
        host_u.write_byte(ADDR_SYS_OPTIONS, 8'h01, 0);
        settle(3);
        check(8'(df_cnt - n), 8'h00, "no force");
        host_u.write_byte(ADDR_DEBUG_FORCE, 8'h01, 20);
        settle(3);
        check(8'(df_cnt - n), 8'h01, "force reset");
        check({5'h00, df_cause}, 8'h01, "force cause");
        do_reset();
        check({7'h00, dbg_pin_en}, 8'h01, "pin after reset");
        cpu_wr(ADDR_SYS_OPTIONS, 8'h80);
        cpu_rd(ADDR_SYS_OPTIONS, 8'h80, "short options");
        check({7'h00, dbg_pin_en}, 8'h00, "pin output mode");
        cpu_wr(ADDR_RESET_STATUS, 8'h00);
        wait_event(1, SHORT, SHORT + 4, "short timeout");
        do_stop(1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire

//--- verilog/sysctl_pkg.sv
// Package for the system options, part identity and periodic wakeup control block.
// Assumes a single 20 MHz bus clock; shared by the top and its two timer modules.
package sysctl_pkg;

    // Register indexes on the register port
    localparam logic [2:0] ADDR_RESET_STATUS = 3'h0;
    localparam logic [2:0] ADDR_DEBUG_FORCE  = 3'h1;
    localparam logic [2:0] ADDR_SYS_OPTIONS  = 3'h2;
    localparam logic [2:0] ADDR_PART_ID_HIGH = 3'h3;
    localparam logic [2:0] ADDR_PART_ID_LOW  = 3'h4;
    localparam logic [2:0] ADDR_WAKEUP_CTRL  = 3'h5;

    // Debug force reset register
    localparam int         DBG_FORCE_BIT     = 0;
    localparam logic [7:0] DBG_FORCE_READ    = 8'h00;

    // System options register fields and reset value
    localparam int         OPT_WDOG_EN_BIT   = 7;
    localparam int         OPT_WDOG_LONG_BIT = 6;
    localparam int         OPT_STOP_BIT      = 5;
    localparam int         OPT_DBG_PIN_BIT   = 1;
    localparam logic [7:0] OPT_RESET         = 8'hc2;
    localparam logic [7:0] OPT_IMPL_MASK     = 8'he3;

    // Wakeup control register fields
    localparam int         WK_FLAG_BIT       = 7;
    localparam int         WK_ACK_BIT        = 6;
    localparam int         WK_CLKSEL_BIT     = 5;
    localparam int         WK_IRQ_EN_BIT     = 4;
    localparam int         WK_PERIOD_LSB     = 0;
    localparam logic [7:0] WK_CTRL_RESET     = 8'h00;

    // Part identification, upper nibble lands in the high register
    localparam logic [11:0] PART_ID_DEFAULT  = 12'ha5c; // Arbitrary value

    // Timing
    localparam int unsigned CLK_PERIOD_NS    = 50;
    localparam int unsigned WDOG_SHORT_LOG2  = 13;
    localparam int unsigned WDOG_LONG_LOG2   = 18;
    localparam int unsigned WDOG_SHORT_CYC   = 1 << WDOG_SHORT_LOG2;
    localparam int unsigned WDOG_LONG_CYC    = 1 << WDOG_LONG_LOG2;
    localparam int unsigned RTI_TICK_NS      = 1150000;
    localparam int unsigned RTI_TICK_CYC     = RTI_TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned RTI_INT_BASE     = 8;
    localparam int          WDOG_CNT_W       = 18;
    localparam int          RTI_DIV_W        = 16;
    localparam int          RTI_CNT_W        = 16;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] data;
    } reg_access_t;

    typedef struct packed {
        logic watchdog;
        logic illegal_opcode;
        logic debug_forced;
    } reset_cause_t;

    // Wakeup period in source ticks; zero means the timer is stopped
    function automatic logic [RTI_CNT_W-1:0] wakeup_ticks(input logic ext_sel,
                                                          input logic [2:0] code);
        logic [RTI_CNT_W-1:0] n;
        n = '0;
        if (!ext_sel) begin
            n = RTI_CNT_W'(RTI_INT_BASE << code);
        end else if (code == 3'h0) begin
            n = '0;
        end else if (code == 3'h1) begin
            n = 16'h0100;
        end else begin
            n = RTI_CNT_W'(32'h0000_0100 << code);
        end
        return n;
    endfunction

endpackage

//--- verilog/system_options_rti_control.sv
// System integration control: debug force reset, write-once options, part identity
// and periodic wakeup control. Assumes the CPU and the debug host command decoder
// present one-cycle register strobes synchronous to ref_clk, and that the reset
// controller outside turns reset_req into a system reset on arst_n.
`timescale 1ns/100ps
`default_nettype none
module system_options_rti_control #(
    parameter logic [11:0] PART_ID          = sysctl_pkg::PART_ID_DEFAULT,
    parameter int unsigned WDOG_SHORT_CYCLES = sysctl_pkg::WDOG_SHORT_CYC,
    parameter int unsigned WDOG_LONG_CYCLES  = sysctl_pkg::WDOG_LONG_CYC,
    parameter int unsigned RTI_TICK_CYCLES   = sysctl_pkg::RTI_TICK_CYC
) (
    // Clock and reset
    input  wire logic                              ref_clk,
    input  wire logic                              arst_n,
    // CPU register port
    input  wire sysctl_pkg::reg_access_t           cpu_access,
    output logic [7:0]                             cpu_rdata,
    output logic                                   cpu_rvalid,
    // Debug host write port
    input  wire sysctl_pkg::reg_access_t           dbg_access,
    // Events from the core and the clock generator
    input  wire logic                              stop_exec,
    input  wire logic                              ext_clk_tick,
    // System requests
    output sysctl_pkg::reset_cause_t               reset_req,
    output logic                                   stop_enter,
    output logic                                   wakeup_irq,
    // Option outputs and wakeup flag
    output logic                                   watchdog_enable,
    output logic                                   watchdog_long_timeout,
    output logic                                   stop_permit,
    output logic                                   debug_pin_enable,
    output logic                                   wakeup_flag
);
    import sysctl_pkg::*;

    // Register state
    logic [7:0] system_options_reg;
    logic       options_locked_reg;
    logic       wakeup_clock_select_reg;
    logic       wakeup_irq_enable_reg;
    logic [2:0] wakeup_period_select_reg;
    logic       wakeup_flag_reg;

    // Decoded strobes
    logic cpu_wr;
    logic cpu_rd;
    logic dbg_wr;
    logic options_wr;
    logic wakeup_wr;
    logic wakeup_ack;
    logic status_wr;
    logic debug_force;
    logic wdog_timeout;
    logic rti_timeout;
    logic illegal_stop;
    logic [7:0] read_value;

    assign cpu_wr = cpu_access.wr;
    assign cpu_rd = cpu_access.rd;
    assign dbg_wr = dbg_access.wr;

    // Address decoding for writes
    always_comb begin
        options_wr  = 1'b0;
        wakeup_wr   = 1'b0;
        status_wr   = 1'b0;
        debug_force = 1'b0;
        if (cpu_wr && cpu_access.addr == ADDR_SYS_OPTIONS) begin
            options_wr = 1'b1;
        end else if (cpu_wr && cpu_access.addr == ADDR_WAKEUP_CTRL) begin
            wakeup_wr = 1'b1;
        end else if (cpu_wr && cpu_access.addr == ADDR_RESET_STATUS) begin
            status_wr = 1'b1;
        end else if (cpu_wr && cpu_access.addr == ADDR_DEBUG_FORCE) begin
            debug_force = 1'b0;
        end
        // Only the debug host path can reach the force bit
        if (dbg_wr && dbg_access.addr == ADDR_DEBUG_FORCE) begin
            debug_force = dbg_access.data[DBG_FORCE_BIT];
        end
    end

    assign wakeup_ack   = wakeup_wr && cpu_access.data[WK_ACK_BIT];
    assign illegal_stop = stop_exec && !system_options_reg[OPT_STOP_BIT];

    // Write-once options; the lock is set by any CPU write, even one that
    // repeats the reset values, so init code must always write it
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            system_options_reg <= OPT_RESET;
            options_locked_reg <= 1'b0;
        end else if (options_wr && !options_locked_reg) begin
            system_options_reg <= cpu_access.data & OPT_IMPL_MASK;
            options_locked_reg <= 1'b1;
        end
    end

    // Wakeup control fields
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wakeup_clock_select_reg  <= WK_CTRL_RESET[WK_CLKSEL_BIT];
            wakeup_irq_enable_reg    <= WK_CTRL_RESET[WK_IRQ_EN_BIT];
            wakeup_period_select_reg <= WK_CTRL_RESET[WK_PERIOD_LSB +: 3];
        end else if (wakeup_wr) begin
            wakeup_clock_select_reg  <= cpu_access.data[WK_CLKSEL_BIT];
            wakeup_irq_enable_reg    <= cpu_access.data[WK_IRQ_EN_BIT];
            wakeup_period_select_reg <= cpu_access.data[WK_PERIOD_LSB +: 3];
        end
    end

    // Wakeup flag: a timeout in the same cycle as an acknowledge is kept
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wakeup_flag_reg <= WK_CTRL_RESET[WK_FLAG_BIT];
        end else if (rti_timeout) begin
            wakeup_flag_reg <= 1'b1;
        end else if (wakeup_ack) begin
            wakeup_flag_reg <= 1'b0;
        end
    end

    watchdog_timer #(
        .SHORT_CYCLES (WDOG_SHORT_CYCLES),
        .LONG_CYCLES  (WDOG_LONG_CYCLES)
    ) u_watchdog (
        .ref_clk      (ref_clk),
        .arst_n       (arst_n),
        .enable       (system_options_reg[OPT_WDOG_EN_BIT]),
        .long_sel     (system_options_reg[OPT_WDOG_LONG_BIT]),
        .clear        (status_wr),
        .timeout      (wdog_timeout)
    );

    // Changing source or period restarts the count so a new period starts clean
    wakeup_timer #(
        .TICK_CYCLES  (RTI_TICK_CYCLES)
    ) u_wakeup (
        .ref_clk      (ref_clk),
        .arst_n       (arst_n),
        .ext_sel      (wakeup_clock_select_reg),
        .period_sel   (wakeup_period_select_reg),
        .restart      (wakeup_wr),
        .ext_tick     (ext_clk_tick),
        .timeout      (rti_timeout)
    );

    // Read data multiplexer
    always_comb begin
        read_value = 8'h00;
        if (cpu_access.addr == ADDR_DEBUG_FORCE) begin
            read_value = DBG_FORCE_READ;
        end else if (cpu_access.addr == ADDR_SYS_OPTIONS) begin
            read_value = system_options_reg & OPT_IMPL_MASK;
        end else if (cpu_access.addr == ADDR_PART_ID_HIGH) begin
            read_value = {4'h0, PART_ID[11:8]};
        end else if (cpu_access.addr == ADDR_PART_ID_LOW) begin
            read_value = PART_ID[7:0];
        end else if (cpu_access.addr == ADDR_WAKEUP_CTRL) begin
            read_value[WK_FLAG_BIT]           = wakeup_flag_reg;
            read_value[WK_CLKSEL_BIT]         = wakeup_clock_select_reg;
            read_value[WK_IRQ_EN_BIT]         = wakeup_irq_enable_reg;
            read_value[WK_PERIOD_LSB +: 3]    = wakeup_period_select_reg;
        end
    end

    // Read answer one cycle after the strobe; unmapped and status reads give zero
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_rdata  <= 8'h00;
            cpu_rvalid <= 1'b0;
        end else begin
            cpu_rvalid <= cpu_rd;
            if (cpu_rd) begin
                cpu_rdata <= read_value;
            end
        end
    end

    // Reset requests; each is a one-cycle pulse naming its cause
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reset_req <= '0;
        end else begin
            reset_req.debug_forced   <= debug_force;
            reset_req.watchdog       <= wdog_timeout && !debug_force;
            reset_req.illegal_opcode <= illegal_stop && !debug_force;
        end
    end

    // Stop entry only when permitted
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stop_enter <= 1'b0;
        end else begin
            stop_enter <= stop_exec && system_options_reg[OPT_STOP_BIT];
        end
    end

    // Interrupt request and option outputs
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wakeup_irq            <= 1'b0;
            wakeup_flag           <= 1'b0;
            watchdog_enable       <= OPT_RESET[OPT_WDOG_EN_BIT];
            watchdog_long_timeout <= OPT_RESET[OPT_WDOG_LONG_BIT];
            stop_permit           <= OPT_RESET[OPT_STOP_BIT];
            debug_pin_enable      <= OPT_RESET[OPT_DBG_PIN_BIT];
        end else begin
            wakeup_irq            <= wakeup_flag_reg && wakeup_irq_enable_reg;
            wakeup_flag           <= wakeup_flag_reg;
            watchdog_enable       <= system_options_reg[OPT_WDOG_EN_BIT];
            watchdog_long_timeout <= system_options_reg[OPT_WDOG_LONG_BIT];
            stop_permit           <= system_options_reg[OPT_STOP_BIT];
            debug_pin_enable      <= system_options_reg[OPT_DBG_PIN_BIT];
        end
    end

endmodule
`default_nettype wire

//--- verilog/wakeup_timer.sv
// Periodic wakeup timer with an internal tick divider or an external tick source.
// Assumes ext_tick is a one-cycle pulse synchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none
module wakeup_timer #(
    parameter int unsigned TICK_CYCLES = sysctl_pkg::RTI_TICK_CYC
) (
    // Clock and reset
    input  wire logic                              ref_clk,
    input  wire logic                              arst_n,
    // Control
    input  wire logic                              ext_sel,
    input  wire logic [2:0]                        period_sel,
    input  wire logic                              restart,
    input  wire logic                              ext_tick,
    // Result
    output logic                                   timeout
);
    import sysctl_pkg::*;

    logic [RTI_DIV_W-1:0] div_reg;
    logic                 int_tick;
    logic [RTI_CNT_W-1:0] count_reg;
    logic [RTI_CNT_W-1:0] target;
    logic                 tick;

    // The internal oscillator stands in as a divided bus clock
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_reg  <= '0;
            int_tick <= 1'b0;
        end else if (div_reg >= RTI_DIV_W'(TICK_CYCLES - 1)) begin
            div_reg  <= '0;
            int_tick <= 1'b1;
        end else begin
            div_reg  <= div_reg + 1'b1;
            int_tick <= 1'b0;
        end
    end

    assign target = wakeup_ticks(ext_sel, period_sel);
    assign tick   = ext_sel ? ext_tick : int_tick;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= '0;
            timeout   <= 1'b0;
        end else begin
            timeout <= 1'b0;
            if (restart || target == '0) begin
                count_reg <= '0;
            end else if (tick) begin
                if (count_reg >= target - 1'b1) begin
                    count_reg <= '0;
                    timeout   <= 1'b1;
                end else begin
                    count_reg <= count_reg + 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

//--- verilog/watchdog_timer.sv
// Watchdog counter: counts bus clocks from its last clear and pulses on timeout.
// Assumes clear and option inputs are synchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none
module watchdog_timer #(
    parameter int unsigned SHORT_CYCLES = sysctl_pkg::WDOG_SHORT_CYC,
    parameter int unsigned LONG_CYCLES  = sysctl_pkg::WDOG_LONG_CYC
) (
    // Clock and reset
    input  wire logic                              ref_clk,
    input  wire logic                              arst_n,
    // Control
    input  wire logic                              enable,
    input  wire logic                              long_sel,
    input  wire logic                              clear,
    // Result
    output logic                                   timeout
);
    import sysctl_pkg::*;

    logic [WDOG_CNT_W-1:0] count_reg;
    logic [WDOG_CNT_W-1:0] limit;

    assign limit = long_sel ? WDOG_CNT_W'(LONG_CYCLES - 1) : WDOG_CNT_W'(SHORT_CYCLES - 1);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= '0;
            timeout   <= 1'b0;
        end else begin
            timeout <= 1'b0;
            if (clear || !enable) begin
                count_reg <= '0;
            end else if (count_reg >= limit) begin
                count_reg <= '0;
                timeout   <= 1'b1;
            end else begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

endmodule
`default_nettype wire
